// ===== rtl/rhp_map.svh
// Constants of the host port and frequency-output gating block.
// Assumes a 10 MHz system clock; half-period ticks come from a phase accumulator.
`ifndef RHP_MAP_SVH
`define RHP_MAP_SVH
// Register address of the low divider nibble (ratio code in bits 2:0)
`define RHP_ADDR_DIV_LO 4'hc
// Register address of the high divider nibble (enable bit 3, source in bits 1:0)
`define RHP_ADDR_DIV_HI 4'hd
`define RHP_BIT_ENABLE 3
// Reset values of the two divider nibbles
`define RHP_RST_DIV_LO 4'h0
`define RHP_RST_DIV_HI 4'h0
// Phase accumulator: one tick per half period of 32768 Hz, so 65536 ticks a second
// from 10 MHz, step = 2^32 * 65536 / 1e7
`define RHP_BASE_HZ 32768
`define RHP_TICK_HZ 65536
`define RHP_CLK_HZ 10000000
`define RHP_PHASE_STEP 32'd28147498
// Last count of each divide-by-32 prescaler between source rates
`define RHP_PRE_1024 5'd31
`define RHP_PRE_32 5'd31
`define RHP_PRE_1 5'd31
`endif

// ===== rtl/rhp_pkg.sv
// Types shared by the host port block.
// Assumes rhp_map.svh supplies the numeric constants.
package rhp_pkg;
  // Host pins sampled each clock
  typedef struct packed {
    logic select_low_n;
    logic select_high;
    logic rd_n;
    logic wr_n;
    logic [3:0] reg_address_in;
    logic [3:0] data_lines;
  } rhp_host_type;
  // Four-line tristate pin group, data with per-line enables
  typedef struct packed {
    logic [3:0] data;
    logic [3:0] oe;
  } rhp_data_drive_type;
  typedef enum logic [1:0] {
    RHP_SRC_32768,
    RHP_SRC_1024,
    RHP_SRC_32,
    RHP_SRC_1
  } rhp_src_type;
endpackage : rhp_pkg

// ===== rtl/rhp_host_port.sv
// Parallel host port with frequency-output gating.
// Assumes host pins are synchronous to clk_i; no other registers live here.
`include "rhp_map.svh"

module rhp_host_port #(
  parameter bit HAS_SOURCE_PIN = 1'b1,
  parameter int NUM_REGS = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire rhp_pkg::rhp_host_type host_i,
  input wire logic freq_out_source_pin_i,
  input wire logic irq_request_i,
  output rhp_pkg::rhp_data_drive_type data_lines_o,
  output logic freq_out_o,
  output logic freq_out_oe_o,
  output logic irq_n_o,
  output logic irq_n_oe_o
);

  // ==========================================================
  // Register file and write capture
  logic [3:0] regs [NUM_REGS];
  logic [3:0] next_regs [NUM_REGS];
  logic wr_n_d;
  logic next_wr_n_d;
  logic access_en;
  logic wr_rise;

  assign access_en = !host_i.select_low_n && host_i.select_high;
  assign wr_rise = !wr_n_d && host_i.wr_n;

  // Write lands on the strobe's rising edge, not while it is low
  always_comb begin
    next_wr_n_d = host_i.wr_n;
    for (int i = 0; i < NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    if (access_en && wr_rise) begin
      next_regs[host_i.reg_address_in] = host_i.data_lines;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_n_d <= 1'b1;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= 4'h0;
      end
      regs[`RHP_ADDR_DIV_LO] <= `RHP_RST_DIV_LO;
      regs[`RHP_ADDR_DIV_HI] <= `RHP_RST_DIV_HI;
    end else begin
      wr_n_d <= next_wr_n_d;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // ==========================================================
  // Read drive of the data lines
  rhp_pkg::rhp_data_drive_type next_data;
  logic reading;
  // Write strobe also low means a host fault; we stay off the bus then
  assign reading = access_en && !host_i.rd_n && host_i.wr_n;

  always_comb begin
    next_data.data = 4'h0;
    next_data.oe = 4'h0;
    if (reading) begin
      next_data.data = regs[host_i.reg_address_in];
      next_data.oe = 4'hf;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      data_lines_o <= '0;
    end else begin
      data_lines_o <= next_data;
    end
  end

  // ==========================================================
  // Half-period tick of the 32768 Hz source; toggling on it gives the full rate
  logic [31:0] phase;
  logic [31:0] next_phase;
  logic [32:0] phase_sum;
  logic tick_base;
  assign phase_sum = {1'b0, phase} + {1'b0, `RHP_PHASE_STEP};
  assign tick_base = phase_sum[32];

  always_comb begin
    next_phase = phase_sum[31:0];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      phase <= 32'h0;
    end else begin
      phase <= next_phase;
    end
  end

  // ==========================================================
  // Prescaled half-period ticks of the 1024, 32 and 1 Hz sources
  logic [4:0] pre_a;
  logic [4:0] pre_b;
  logic [9:0] pre_c;
  logic [4:0] next_pre_a;
  logic [4:0] next_pre_b;
  logic [9:0] next_pre_c;
  logic tick_1024;
  logic tick_32;
  logic tick_1;
  assign tick_1024 = tick_base && (pre_a == `RHP_PRE_1024);
  assign tick_32 = tick_1024 && (pre_b == `RHP_PRE_32);
  assign tick_1 = tick_32 && (pre_c[4:0] == `RHP_PRE_1);

  always_comb begin
    next_pre_a = pre_a;
    next_pre_b = pre_b;
    next_pre_c = pre_c;
    if (tick_base) begin
      next_pre_a = pre_a + 5'h1;
    end
    if (tick_1024) begin
      next_pre_b = pre_b + 5'h1;
    end
    if (tick_32) begin
      next_pre_c = pre_c + 10'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pre_a <= 5'h0;
      pre_b <= 5'h0;
      pre_c <= 10'h0;
    end else begin
      pre_a <= next_pre_a;
      pre_b <= next_pre_b;
      pre_c <= next_pre_c;
    end
  end

  // ==========================================================
  // Divider: pick source, divide by ratio, toggle output
  rhp_pkg::rhp_src_type src_sel;
  logic [2:0] ratio_code;
  logic freq_enable;
  logic src_tick;
  logic [4:0] ratio_m1;
  logic [4:0] div_cnt;
  logic [4:0] next_div_cnt;
  logic div_level;
  logic next_div_level;
  logic base_level;
  logic next_base_level;

  assign src_sel = rhp_pkg::rhp_src_type'(regs[`RHP_ADDR_DIV_HI][1:0]);
  assign ratio_code = regs[`RHP_ADDR_DIV_LO][2:0];
  assign freq_enable = regs[`RHP_ADDR_DIV_HI][`RHP_BIT_ENABLE];

  // Ratio codes map to 1,2,3,6,5,10,15,30
  always_comb begin
    case (ratio_code)
      3'd0: ratio_m1 = 5'd0;
      3'd1: ratio_m1 = 5'd1;
      3'd2: ratio_m1 = 5'd2;
      3'd3: ratio_m1 = 5'd5;
      3'd4: ratio_m1 = 5'd4;
      3'd5: ratio_m1 = 5'd9;
      3'd6: ratio_m1 = 5'd14;
      default: ratio_m1 = 5'd29;
    endcase
  end

  always_comb begin
    case (src_sel)
      rhp_pkg::RHP_SRC_32768: src_tick = tick_base;
      rhp_pkg::RHP_SRC_1024: src_tick = tick_1024;
      rhp_pkg::RHP_SRC_32: src_tick = tick_32;
      default: src_tick = tick_1;
    endcase
  end

  // Source ticks mark half periods, so toggling every ratio ticks gives
  // source / ratio with even duty, odd ratios included
  always_comb begin
    next_div_cnt = div_cnt;
    next_div_level = div_level;
    next_base_level = base_level;
    if (tick_base) begin
      next_base_level = !base_level;
    end
    if (src_tick) begin
      if (div_cnt >= ratio_m1) begin
        next_div_cnt = 5'h0;
        next_div_level = !div_level;
      end else begin
        next_div_cnt = div_cnt + 5'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      div_cnt <= 5'h0;
      div_level <= 1'b0;
      base_level <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      div_level <= next_div_level;
      base_level <= next_base_level;
    end
  end

  // ==========================================================
  // Frequency output gating and open-drain interrupt
  logic source_eff;
  logic next_freq_out;
  logic next_freq_out_oe;
  assign source_eff = HAS_SOURCE_PIN ? freq_out_source_pin_i : 1'b1;

  always_comb begin
    next_freq_out = 1'b0;
    next_freq_out_oe = 1'b0;
    if (host_i.select_high) begin
      if (!source_eff) begin
        next_freq_out = base_level;
        next_freq_out_oe = 1'b1;
      end else if (freq_enable) begin
        next_freq_out = div_level;
        next_freq_out_oe = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      freq_out_o <= 1'b0;
      freq_out_oe_o <= 1'b0;
      irq_n_o <= 1'b0;
      irq_n_oe_o <= 1'b0;
    end else begin
      freq_out_o <= next_freq_out;
      freq_out_oe_o <= next_freq_out_oe;
      irq_n_o <= 1'b0;
      irq_n_oe_o <= irq_request_i;
    end
  end

  // ==========================================================
  // Checks
  sequence s_write_edge;
    access_en && !host_i.wr_n ##1 access_en && host_i.wr_n;
  endsequence

  a_access_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !access_en |=> data_lines_o.oe == 4'h0)
    else $error("data driven without access");
  a_read_data: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    reading |=> data_lines_o.oe == 4'hf && data_lines_o.data == $past(next_data.data))
    else $error("read data wrong");
  a_release_bus: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    host_i.rd_n |=> data_lines_o.oe == 4'h0)
    else $error("bus not released");
  a_write_capture: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_write_edge |=> regs[$past(host_i.reg_address_in)] == $past(host_i.data_lines))
    else $error("write not captured");
  a_freq_out_cs_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !host_i.select_high |=> !freq_out_oe_o)
    else $error("freq_out driven with select_high low");
  a_freq_out_base: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    host_i.select_high && !source_eff |=> freq_out_oe_o && freq_out_o == $past(base_level))
    else $error("base clock not output");
  a_freq_out_enable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    host_i.select_high && source_eff && !freq_enable |=> !freq_out_oe_o)
    else $error("freq_out driven while disabled");
  a_irq_drain: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    irq_n_oe_o |-> !irq_n_o)
    else $error("interrupt driven high");
  a_src_pin_tie: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !HAS_SOURCE_PIN |-> source_eff)
    else $error("source pin not tied high");

endmodule : rhp_host_port

// ===== dv/rhp_host_model.sv
// Host processor model that drives the parallel port pins of the block.
// Assumes the bench calls its tasks from the falling clock edge.
module rhp_host_model (
  input wire logic clk_i,
  input wire rhp_pkg::rhp_data_drive_type dev_i,
  output rhp_pkg::rhp_host_type host_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Pin state
  logic sel_n = 1'b1; // Power-on level kept high
  logic sel_h = 1'b0;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic drv = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] wdata = 4'h0;
  logic [3:0] last = 4'h0;
  logic [3:0] line;
  // Wire level; an undriven line shows the inverse of its last value
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      line[b] = dev_i.oe[b] ? dev_i.data[b] : (drv ? wdata[b] : ~last[b]);
    end
  end
  always @(posedge clk_i) last <= line;
  assign host_o = {sel_n, sel_h, rd_n, wr_n, addr, line};
  // ==========
  // Bus cycles
  task automatic set_sel(input logic sn, input logic sh);
    @(negedge clk_i);
    sel_n = sn;
    sel_h = sh;
  endtask : set_sel
  // Write strobe alone goes low, never with the read strobe
  task automatic write(input logic [3:0] a, input logic [3:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    drv = 1'b1;
    wr_n = 1'b0;
    @(negedge clk_i);
    wr_n = 1'b1;
    @(negedge clk_i);
    drv = 1'b0;
  endtask : write
  // Read strobe held two edges, wire level taken before release
  task automatic read(input logic [3:0] a, output logic [3:0] d, output logic [3:0] oe);
    @(negedge clk_i);
    addr = a;
    rd_n = 1'b0;
    repeat (2) @(negedge clk_i);
    d = line;
    oe = dev_i.oe;
    rd_n = 1'b1;
  endtask : read
endmodule : rhp_host_model

// ===== dv/test_rtc_host_port_freq_out_gating.sv
// Self-checking bench of the host port and frequency-output gating.
// Assumes rhp_pkg is compiled first and rhp_host_model plays the host.
module test_rtc_host_port_freq_out_gating;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FW = 3100;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic src_pin = 1'b1;
  logic irq_req = 1'b0;
  rhp_pkg::rhp_host_type host;
  rhp_pkg::rhp_data_drive_type dl;
  logic fo, fo_oe, irq_n, irq_oe;
  logic np_oe;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 59;
  int mem [16];
  int ratio [4] = '{1, 2, 3, 6};
  logic [3:0] rd, oe;
  always #50 clk_i = ~clk_i;
  rhp_host_port dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .host_i(host),
    .freq_out_source_pin_i(src_pin), .irq_request_i(irq_req), .data_lines_o(dl),
    .freq_out_o(fo), .freq_out_oe_o(fo_oe), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe));
  // Variant without the source pin: its input must be ignored
  rhp_host_port #(.HAS_SOURCE_PIN(1'b0)) dut_np (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .host_i(host), .freq_out_source_pin_i(src_pin), .irq_request_i(irq_req),
    .data_lines_o(), .freq_out_o(), .freq_out_oe_o(np_oe), .irq_n_o(), .irq_n_oe_o());
  rhp_host_model hm (.clk_i(clk_i), .dev_i(dl), .host_o(host));
  // ==========
  // Shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Read, compare, then see the lines let go
  task automatic read_cmp(input logic [3:0] a, input int exp);
    hm.read(a, rd, oe);
    check("read data", {4'h0, rd}, 8'(exp));
    check("read drive", {4'h0, oe}, 8'h0f);
    repeat (2) @(negedge clk_i);
    check("released", {4'h0, dl.oe}, 8'h00);
  endtask : read_cmp
  // Drive state, then toggle count against twice the source rate over ratio
  task automatic freq_out_meas(input int src, input int r, input int win, input logic exp_oe);
    int n;
    logic prev;
    longint dev;
    n = 0;
    repeat (4) @(negedge clk_i);
    check("freq_out drive", {7'h0, fo_oe}, {7'h0, exp_oe});
    prev = fo;
    if (exp_oe && win > 0) begin
      repeat (win) begin
        @(negedge clk_i);
        if (fo !== prev) n++;
        prev = fo;
      end
      dev = longint'(n) * 10000000 * r - longint'(win) * src * 2;
      check("toggles", {7'h0, dev <= 15000000 * r && dev >= -15000000 * r}, 8'h01);
    end
  endtask : freq_out_meas
  // ==========
  // Main sequence
  initial begin
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    @(negedge clk_i);
    check("reset oe", {dl.oe, 2'b0, fo_oe, irq_oe}, 8'h00);
    hm.set_sel(1'b0, 1'b1);
    for (int a = 0; a < 16; a++) read_cmp(4'(a), 0);
    for (int a = 0; a < 16; a++) begin
      mem[a] = $random(seed) & 15;
      hm.write(4'(a), 4'(mem[a]));
    end
    for (int a = 0; a < 16; a++) read_cmp(4'(a), mem[a]);
    // Every denied select pair: no write lands, no read drives
    for (int k = 0; k < 3; k++) begin
      hm.set_sel(k != 1, k == 0);
      hm.write(4'h5, ~4'(mem[5]));
      hm.read(4'h5, rd, oe);
      check("denied drive", {4'h0, oe}, 8'h00);
    end
    hm.set_sel(1'b0, 1'b1);
    read_cmp(4'h5, mem[5]);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_i);
      irq_req = 1'($random(seed));
      @(negedge clk_i);
      check("irq pull", {6'h0, irq_n, irq_oe}, {7'h0, irq_req});
    end
    hm.write(4'hc, 4'h0);
    hm.write(4'hd, 4'h0);
    src_pin = 1'b1;
    freq_out_meas(32768, 1, FW, 1'b0);
    src_pin = 1'b0;
    freq_out_meas(32768, 1, FW, 1'b1);
    check("no pin oe", {7'h0, np_oe}, 8'h00);
    hm.set_sel(1'b1, 1'b1);
    freq_out_meas(32768, 1, FW, 1'b1);
    hm.set_sel(1'b1, 1'b0);
    freq_out_meas(32768, 1, FW, 1'b0);
    hm.set_sel(1'b0, 1'b1);
    src_pin = 1'b1;
    hm.write(4'hd, 4'h8);
    for (int k = 0; k < 4; k++) begin
      hm.write(4'hc, 4'(k));
      freq_out_meas(32768, ratio[k], FW, 1'b1);
    end
    // Pin low would force the base clock, but the variant ignores it
    src_pin = 1'b0;
    repeat (2) @(negedge clk_i);
    check("no pin oe", {7'h0, np_oe}, 8'h01);
    src_pin = 1'b1;
    // Slower sources: 1024 Hz measured, 32 and 1 Hz too slow, drive only
    hm.write(4'hc, 4'h0);
    hm.write(4'hd, 4'h9);
    freq_out_meas(1024, 1, 20000, 1'b1);
    for (int s = 2; s < 4; s++) begin
      hm.write(4'hd, 4'(8 + s));
      freq_out_meas(1, 1, 0, 1'b1);
    end
    wrap_up();
  end
  // Hang guard: the run needs about 39000 cycles, so about half as much again
  initial begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    wrap_up();
  end
endmodule : test_rtc_host_port_freq_out_gating
